// [core/strd_det_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module strd_det_timer
    import strd_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] interval,
    output logic            dclk_tick,
    output logic            scan_tick
);
    // ==========================================================
    // Prescaler and interval counter.
    logic [11:0] pre_q;
    logic [7:0]  int_q;
    wire         pre_wrap = (pre_q == DCLK_LAST);
    wire         int_wrap = pre_wrap && (int_q >= interval);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pre_q     <= 12'h000;
            int_q     <= 8'h00;
            dclk_tick <= 1'b0;
            scan_tick <= 1'b0;
        end else begin
            pre_q     <= pre_wrap ? 12'h000 : pre_q + 12'h001;
            dclk_tick <= pre_wrap;
            scan_tick <= int_wrap;
            if (int_wrap) begin
                int_q <= 8'h00;
            end else if (pre_wrap) begin
                int_q <= int_q + 8'h01;
            end
        end
    end

    a_dclk_period: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(dclk_tick) |-> ##1 !dclk_tick [*8])
        else $error("detect clock tick repeated too soon");
endmodule
`default_nettype wire

// [core/strd_pkg.sv]
package strd_pkg;
    // ==========================================================
    // Register indices and byte addresses.
    localparam logic [3:0]  IDX_FUSE_ADDR   = 4'h4;
    localparam logic [3:0]  IDX_FUSE_WDATA  = 4'h5;
    localparam logic [3:0]  IDX_FUSE_CTRL   = 4'h6;
    localparam logic [3:0]  IDX_FUSE_RDATA  = 4'h7;
    localparam logic [3:0]  IDX_THRESHOLD   = 4'h8;
    localparam logic [3:0]  IDX_INTERVAL    = 4'h9;
    localparam logic [3:0]  IDX_ENABLES     = 4'ha;
    localparam logic [3:0]  IDX_DET_STATUS  = 4'hb;
    localparam logic [3:0]  IDX_LINE_SUM    = 4'hc;
    localparam logic [7:0]  ADDR_FUSE_ADDR  = {2'h0, IDX_FUSE_ADDR, 2'h0};
    localparam logic [7:0]  ADDR_FUSE_WDATA = {2'h0, IDX_FUSE_WDATA, 2'h0};
    localparam logic [7:0]  ADDR_FUSE_CTRL  = {2'h0, IDX_FUSE_CTRL, 2'h0};
    localparam logic [7:0]  ADDR_FUSE_RDATA = {2'h0, IDX_FUSE_RDATA, 2'h0};
    localparam logic [7:0]  ADDR_THRESHOLD  = {2'h0, IDX_THRESHOLD, 2'h0};
    localparam logic [7:0]  ADDR_INTERVAL   = {2'h0, IDX_INTERVAL, 2'h0};
    localparam logic [7:0]  ADDR_ENABLES    = {2'h0, IDX_ENABLES, 2'h0};
    localparam logic [7:0]  ADDR_DET_STATUS = {2'h0, IDX_DET_STATUS, 2'h0};
    localparam logic [7:0]  ADDR_LINE_SUM   = {2'h0, IDX_LINE_SUM, 2'h0};
    // ==========================================================
    // Reset values.
    localparam logic [7:0]  RST_FUSE_ADDR   = 8'h00;
    localparam logic [7:0]  RST_FUSE_WDATA  = 8'h00;
    localparam logic [7:0]  RST_FUSE_CTRL   = 8'h00;
    localparam logic [7:0]  RST_THRESHOLD   = 8'hff;
    localparam logic [7:0]  RST_INTERVAL    = 8'h00;
    localparam logic [7:0]  RST_ENABLES     = 8'h00;
    // ==========================================================
    // Field positions.
    localparam int          TRIM_HI_MSB     = 7;
    localparam int          TRIM_HI_LSB     = 6;
    localparam int          NIB_MSB         = 7;
    localparam int          NIB_LSB         = 4;
    localparam int          FADDR_MSB       = 4;
    localparam int          WIN_EN_BIT      = 7;
    localparam int          FUSE_DEPTH      = 32;
    // ==========================================================
    // Timing: detect clock is the core clock divided by 4096.
    localparam int          DCLK_DIV        = 4096;
    localparam logic [11:0] DCLK_LAST       = 12'(DCLK_DIV - 1);
    // ==========================================================
    // Bus encodings and scan state encoding.
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
    typedef enum logic [1:0] {
        STRD_IDLE = 2'b01,
        STRD_WAIT = 2'b10
    } strd_scan_e;
endpackage

// [core/strd_regs.sv]
// Function
// - Trim bits 9:8 in fuse address bits 7:6
// - Trim bits 7:4 in write-data upper nibble
// - Trim bits 3:0 in control upper nibble
// - Threshold compared against line-sum high byte
// - Threshold resets to all ones
// - Detect clock is core clock over 4096
// - Scan interval lasts divider plus one ticks
// - Window enable bit restricts image
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module strd_regs
    import strd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [15:0] line_sum,
    input  wire logic        line_sum_valid,
    output logic [9:0]       coarse_offset_trim,
    output logic             window_enable,
    output logic             scan_start,
    output logic             finger_present
);
    // ==========================================================
    // Registers.
    logic [7:0]  faddr_q;
    logic [7:0]  fwdata_q;
    logic [7:0]  fctrl_q;
    logic [7:0]  thresh_q;
    logic [7:0]  interval_q;
    logic [7:0]  enables_q;
    logic [7:0]  fuse_mem [FUSE_DEPTH];
    logic [7:0]  fuse_read_value;
    logic        finger_q;
    logic [7:0]  sum_hi_q;
    logic        wr_q;
    logic [7:0]  addr_q;
    logic        dclk_tick;
    strd_scan_e  scan_q;

    // ==========================================================
    // Bus address phase.
    wire         bus_req  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wire         wr_fa    = wr_q && (addr_q == ADDR_FUSE_ADDR);
    wire         wr_fw    = wr_q && (addr_q == ADDR_FUSE_WDATA);
    wire         wr_fc    = wr_q && (addr_q == ADDR_FUSE_CTRL);
    wire         wr_th    = wr_q && (addr_q == ADDR_THRESHOLD);
    wire         wr_iv    = wr_q && (addr_q == ADDR_INTERVAL);
    wire         wr_en    = wr_q && (addr_q == ADDR_ENABLES);
    wire [7:0]   wbyte    = hwdata[7:0];
    wire [4:0]   fuse_sel = faddr_q[FADDR_MSB:0];
    wire         fuse_wr  = wr_fc && wbyte[0];
    wire [7:0]   rd_sel;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wr_q   <= 1'b0;
            addr_q <= 8'h00;
        end else if (bus_req) begin
            wr_q   <= hwrite;
            addr_q <= {haddr[7:2], 2'h0};
        end else begin
            wr_q   <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            faddr_q    <= RST_FUSE_ADDR;
            fwdata_q   <= RST_FUSE_WDATA;
            fctrl_q    <= RST_FUSE_CTRL;
            thresh_q   <= RST_THRESHOLD;
            interval_q <= RST_INTERVAL;
            enables_q  <= RST_ENABLES;
        end else begin
            if (wr_fa) faddr_q    <= {wbyte[7:6], 1'b0, wbyte[4:0]};
            if (wr_fw) fwdata_q   <= {wbyte[7:4], 4'h0};
            if (wr_fc) fctrl_q    <= {wbyte[7:4], 4'h0};
            if (wr_th) thresh_q   <= wbyte;
            if (wr_iv) interval_q <= wbyte;
            if (wr_en) enables_q  <= {wbyte[7], 7'h00};
        end
    end

    // ==========================================================
    // Fuse byte store; bit 0 written to control commits one byte.
    always_ff @(posedge core_clk) begin
        if (fuse_wr) begin
            fuse_mem[fuse_sel] <= fwdata_q;
        end
    end
    assign fuse_read_value = fuse_mem[fuse_sel];

    assign coarse_offset_trim = {faddr_q[TRIM_HI_MSB:TRIM_HI_LSB],
                                 fwdata_q[NIB_MSB:NIB_LSB],
                                 fctrl_q[NIB_MSB:NIB_LSB]};
    assign window_enable = enables_q[WIN_EN_BIT];
    assign finger_present = finger_q;

    // ==========================================================
    // Read data; writes to fuse read data decode to nothing.
    assign rd_sel = (addr_q == ADDR_FUSE_ADDR)  ? faddr_q :
                    (addr_q == ADDR_FUSE_WDATA) ? fwdata_q :
                    (addr_q == ADDR_FUSE_CTRL)  ? fctrl_q :
                    (addr_q == ADDR_FUSE_RDATA) ? fuse_read_value :
                    (addr_q == ADDR_THRESHOLD)  ? thresh_q :
                    (addr_q == ADDR_INTERVAL)   ? interval_q :
                    (addr_q == ADDR_ENABLES)    ? enables_q :
                    (addr_q == ADDR_DET_STATUS) ? {7'h00, finger_q} :
                    (addr_q == ADDR_LINE_SUM)   ? sum_hi_q : 8'h00;
    assign hrdata = {24'h000000, rd_sel};

    // ==========================================================
    // Detection scan sequencing and threshold compare.
    strd_det_timer u_timer (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .interval  (interval_q),
        .dclk_tick (dclk_tick),
        .scan_tick (scan_start)
    );

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            scan_q   <= STRD_IDLE;
            finger_q <= 1'b0;
            sum_hi_q <= 8'h00;
        end else begin
            case (scan_q)
                STRD_IDLE: begin
                    if (scan_start) scan_q <= STRD_WAIT;
                end
                STRD_WAIT: begin
                    if (line_sum_valid) begin
                        scan_q   <= STRD_IDLE;
                        sum_hi_q <= line_sum[15:8];
                        finger_q <= (line_sum[15:8] > thresh_q);
                    end
                end
                default: scan_q <= STRD_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Scan spacing monitor; a period in which the divider was written is not checked.
    logic [19:0] gap_q;
    logic        gap_ok_q;
    wire  [19:0] gap_len = 20'(({1'b0, interval_q} + 9'h001) * DCLK_DIV - 1);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            gap_q    <= 20'h00000;
            gap_ok_q <= 1'b0;
        end else begin
            gap_q    <= scan_start ? 20'h00000 : gap_q + 20'h00001;
            if (wr_iv) begin
                gap_ok_q <= 1'b0;
            end else if (scan_start) begin
                gap_ok_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks.
    a_thresh_reset: assert property (@(posedge core_clk)
        $rose(reset_n) |-> thresh_q == 8'hff)
        else $error("threshold not all ones after reset");

    a_trim_split: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_fa |=> coarse_offset_trim[9:8] == $past(wbyte[7:6]))
        else $error("trim top bits not taken from fuse address");

    a_trim_mid: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_fw |=> coarse_offset_trim[7:4] == $past(wbyte[7:4]) && fwdata_q[3:0] == 4'h0)
        else $error("trim middle nibble wrong");

    a_trim_low: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_fc |=> coarse_offset_trim[3:0] == $past(wbyte[7:4]) && fctrl_q[3:0] == 4'h0)
        else $error("trim low nibble wrong");

    sequence s_sum_seen;
        scan_q == STRD_WAIT && line_sum_valid;
    endsequence
    a_detect_cmp: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_sum_seen |=> finger_q == ($past(line_sum[15:8]) > $past(thresh_q)))
        else $error("finger flag disagrees with threshold");

    a_window_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_en |=> window_enable == $past(wbyte[7]))
        else $error("window enable not following bit 7");

    a_rdata_ro: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_q && addr_q == ADDR_FUSE_RDATA |=> $stable(fuse_read_value) || $past(fuse_wr))
        else $error("write to fuse read data had an effect");

    a_scan_gap: assert property (@(posedge core_clk) disable iff (!reset_n)
        scan_start |-> dclk_tick ##1 !scan_start [*8])
        else $error("scan start repeated too soon");

    a_fuse_sel: assert property (@(posedge core_clk) disable iff (!reset_n)
        fuse_wr ##1 $stable(faddr_q) |-> fuse_read_value == $past(fwdata_q))
        else $error("fuse byte not returned at its address");

    a_faddr_resv: assert property (@(posedge core_clk) disable iff (!reset_n)
        faddr_q[FADDR_MSB+1] == 1'b0)
        else $error("unused fuse address bit not zero");

    a_faddr_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_fa |=> faddr_q[FADDR_MSB:0] == $past(wbyte[FADDR_MSB:0]))
        else $error("fuse byte address not taken from write");

    a_trim_hi_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !wr_fa |=> $stable(coarse_offset_trim[9:8]))
        else $error("trim top bits changed without a write");

    a_trim_mid_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !wr_fw |=> $stable(coarse_offset_trim[7:4]))
        else $error("trim middle nibble changed without a write");

    a_trim_low_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !wr_fc |=> $stable(coarse_offset_trim[3:0]))
        else $error("trim low nibble changed without a write");

    a_wdata_resv: assert property (@(posedge core_clk) disable iff (!reset_n)
        fwdata_q[NIB_LSB-1:0] == 4'h0)
        else $error("write data reserved bits not zero");

    a_ctrl_resv: assert property (@(posedge core_clk) disable iff (!reset_n)
        fctrl_q[NIB_LSB-1:0] == 4'h0)
        else $error("control reserved bits not zero");

    a_sum_capture: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_sum_seen |=> sum_hi_q == $past(line_sum[15:8]))
        else $error("line sum high byte not captured");

    a_finger_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(scan_q == STRD_WAIT && line_sum_valid) |=> $stable(finger_q) && $stable(sum_hi_q))
        else $error("finger flag changed outside a scan");

    a_status_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        addr_q == ADDR_DET_STATUS |-> hrdata == {31'h0, finger_q} && finger_present == finger_q)
        else $error("finger flag not shown on status");

    a_thresh_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_th |=> thresh_q == $past(wbyte))
        else $error("threshold not taken from write");

    a_thresh_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !wr_th |=> $stable(thresh_q))
        else $error("threshold changed without a write");

    a_interval_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_iv |=> interval_q == $past(wbyte))
        else $error("divider not taken from write");

    a_interval_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !wr_iv |=> $stable(interval_q))
        else $error("divider changed without a write");

    a_scan_spacing: assert property (@(posedge core_clk) disable iff (!reset_n)
        scan_start && gap_ok_q |-> gap_q == gap_len)
        else $error("scan interval length wrong");

    sequence s_scan_begin;
        scan_q == STRD_IDLE && scan_start;
    endsequence

    a_scan_enter: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_scan_begin |=> scan_q == STRD_WAIT)
        else $error("scan start did not open a scan");

    a_scan_onehot: assert property (@(posedge core_clk) disable iff (!reset_n)
        $onehot(scan_q))
        else $error("scan state not one-hot");

    a_window_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !wr_en |=> $stable(window_enable))
        else $error("window enable changed without a write");

    a_enables_resv: assert property (@(posedge core_clk) disable iff (!reset_n)
        enables_q[WIN_EN_BIT-1:0] == 7'h00)
        else $error("enable register reserved bits not zero");

    a_rdata_nowrite: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_q && addr_q == ADDR_FUSE_RDATA |=> $stable(faddr_q) && $stable(fwdata_q)
            && $stable(fctrl_q) && $stable(thresh_q) && $stable(interval_q) && $stable(enables_q))
        else $error("write to fuse read data changed a register");
endmodule
`default_nettype wire

// [tb/sensor_trim_and_detect_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sensor_trim_and_detect_regs_bench;
    import strd_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] line_sum = 16'h0;
    logic        line_sum_valid = 1'b0;
    logic [9:0]  coarse_offset_trim;
    logic        window_enable, scan_start, finger_present;
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    int          n;

    always #12.5 core_clk = ~core_clk;

    strd_regs i_dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .line_sum(line_sum), .line_sum_valid(line_sum_valid),
        .coarse_offset_trim(coarse_offset_trim), .window_enable(window_enable),
        .scan_start(scan_start), .finger_present(finger_present));

    strd_host i_host (.core_clk(core_clk), .hreadyout(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // ==========================================================
    // Verdict and comparisons.
    task automatic stop_test();
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp);
        checked++;
        if (got != exp) begin
            fail_count++;
            $display("Error at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Register access and stimulus helpers.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        i_host.xfer(1'b1, a, d, q);
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        i_host.xfer(1'b0, a, 8'h00, q);
        check_val(q, {24'h0, e});
    endtask

    task automatic pulse(input logic [15:0] v);
        int k;
        wait_scan(k);
        @(posedge core_clk);
        line_sum       <= v;
        line_sum_valid <= 1'b1;
        @(posedge core_clk);
        line_sum_valid <= 1'b0;
    endtask

    task automatic wait_scan(output int k);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (scan_start !== 1'b1 && k < 20000);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            stop_test();
        end
    end

    // ==========================================================
    // Test sequence.
    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        chk(8'h10, 8'h00);
        chk(8'h14, 8'h00);
        chk(8'h18, 8'h00);
        chk(8'h20, 8'hff);
        chk(8'h24, 8'h00);
        chk(8'h28, 8'h00);
        check_val({22'h0, coarse_offset_trim}, 32'h0);
        wr(8'h10, 8'hff);
        chk(8'h10, 8'hdf);
        wr(8'h14, 8'hff);
        chk(8'h14, 8'hf0);
        wr(8'h18, 8'hfe);
        chk(8'h18, 8'hf0);
        wr(8'h10, 8'h83);
        wr(8'h14, 8'h50);
        wr(8'h18, 8'h30);
        @(negedge core_clk);
        check_val({22'h0, coarse_offset_trim}, 32'h253);
        @(posedge core_clk);
        wr(8'h18, 8'h31);
        chk(8'h18, 8'h30);
        wr(8'h10, 8'h84);
        wr(8'h14, 8'ha0);
        wr(8'h18, 8'h31);
        chk(8'h1c, 8'ha0);
        wr(8'h10, 8'h83);
        chk(8'h1c, 8'h50);
        wr(8'h1c, 8'h55);
        check_val({30'h0, hreadyout, hresp}, 32'h2);
        chk(8'h1c, 8'h50);
        check_val({22'h0, coarse_offset_trim}, 32'h2a3);
        wr(8'h20, 8'h40);
        chk(8'h20, 8'h40);
        pulse(16'h4100);
        chk(8'h2c, 8'h01);
        check_val({31'h0, finger_present}, 32'h1);
        pulse(16'h40ff);
        chk(8'h2c, 8'h00);
        check_val({31'h0, finger_present}, 32'h0);
        wr(8'h28, 8'h80);
        @(negedge core_clk);
        check_val({31'h0, window_enable}, 32'h1);
        @(posedge core_clk);
        wr(8'h28, 8'h00);
        @(negedge core_clk);
        check_val({31'h0, window_enable}, 32'h0);
        @(posedge core_clk);
        chk(8'h3c, 8'h00);
        wr(8'h24, 8'h00);
        wait_scan(n);
        wait_scan(n);
        check_cnt(n, 4096);
        wr(8'h24, 8'h02);
        wait_scan(n);
        wait_scan(n);
        check_cnt(n, 3 * 4096);
        stop_test();
    end
endmodule
`default_nettype wire

// [tb/strd_host.sv]
`timescale 1ns/1ps
`default_nettype none
module strd_host
    import strd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // ==========================================================
    // Idle bus at time zero.
    initial begin
        hsel   = 1'b1;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // ==========================================================
    // One single word transfer, waiting on the slave's ready.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        logic r;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do begin
            @(negedge core_clk);
            r = hreadyout;
            @(posedge core_clk);
        end while (!r);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do begin
            @(negedge core_clk);
            r = hreadyout;
            q = hrdata;
            @(posedge core_clk);
        end while (!r);
    endtask
endmodule
`default_nettype wire
